// *** src/ucs_pkg.sv ***
// package for the serial port control block: register map, field positions,
// reset values and bit timing. assumes a 125 MHz system clock.
package ucs_pkg;
  // register byte addresses
  localparam logic [11:0] DATA_OFS      = 12'h000;
  localparam logic [11:0] STATUS_OFS    = 12'h018;
  localparam logic [11:0] CTRL_OFS      = 12'h030;
  // control register fields
  localparam int          MASTER_BIT    = 0;
  localparam int          SIR_EN_BIT    = 1;
  localparam int          SIR_LP_BIT    = 2;
  localparam int          LOOP_BIT      = 7;
  localparam int          TXE_BIT       = 8;
  localparam int          RXE_BIT       = 9;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0300;
  // status register fields
  localparam int          ST_TX_FULL    = 0;
  localparam int          ST_TX_BUSY    = 1;
  localparam int          ST_RX_VALID   = 2;
  localparam int          ST_RX_BUSY    = 3;
  // bit timing
  localparam int          CLK_HZ        = 125000000;
  localparam int          BAUD_RATE     = 115200;
  localparam logic [6:0]  BAUD16_DIV    = 7'(CLK_HZ / (BAUD_RATE * 16));
  localparam logic [3:0]  LAST_TICK     = 4'hF;
  localparam logic [3:0]  MID_TICK      = 4'h7;
  localparam logic [3:0]  SIR_TICKS     = 4'h3;
  localparam logic [1:0]  LP_LAST       = 2'h3;
  localparam logic [2:0]  LAST_DATA_BIT = 3'h7;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ucs_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ucs_rx_e;

  typedef struct packed {
    logic        master;
    logic        sir;
    logic        lp;
    logic        loop;
    logic        transmit_section_enable;
    logic        receive_section_enable;
    logic [6:0]  div_cnt;
    logic        tick;
    ucs_tx_e     tx_st;
    logic [3:0]  tx_tick;
    logic [2:0]  tx_bitn;
    logic [7:0]  tx_shift;
    logic [7:0]  tx_buf;
    logic        tx_full;
    logic        tx_line;
    logic        lp_on;
    logic [1:0]  lp_cnt;
    logic        ref_prev;
    ucs_rx_e     rx_st;
    logic [3:0]  rx_tick;
    logic [2:0]  rx_bitn;
    logic [7:0]  rx_shift;
    logic [7:0]  rx_buf;
    logic        rx_valid;
    logic        rx_mid;
    logic        rx_zero;
    logic        ap_valid;
    logic        ap_write;
    logic [11:0] ap_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
  } ucs_state_s;
endpackage : ucs_pkg

// *** src/ucs_serial_port.sv ***
// serial port with master/transmit/receive enables, loopback and infrared
// encoder/decoder, registers on an ahb-lite slave port.
// assumes synchronous inputs and a single-slave bus (hreadyout is hready).
`timescale 1ns/1ns
module ucs_serial_port (
  // system
  input  wire logic        clock,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial side
  output logic             serial_transmit_line,
  input  wire logic        serial_receive_line,
  input  wire logic        low_power_baud16_reference
);
  ucs_pkg::ucs_state_s s_reg;
  ucs_pkg::ucs_state_s s_next;
  logic                hresp_reg;

  // nrz level of the bit now on the transmit path
  function automatic logic tx_bit(input ucs_pkg::ucs_state_s st);
    case (st.tx_st)
      ucs_pkg::TX_START: tx_bit = 1'b0;
      ucs_pkg::TX_DATA:  tx_bit = st.tx_shift[0];
      default:           tx_bit = 1'b1;
    endcase
  endfunction : tx_bit

  // pin level: nrz, or infrared pulse that is high only for zero bits
  function automatic logic line_of(input ucs_pkg::ucs_state_s st);
    logic zero;
    zero = ~tx_bit(st) & (st.tx_st != ucs_pkg::TX_IDLE);
    if (!st.sir)
      line_of = tx_bit(st);
    else if (st.lp)
      line_of = zero & st.lp_on & (st.lp_cnt != 2'h0);
    else
      line_of = zero & (st.tx_tick < ucs_pkg::SIR_TICKS);
  endfunction : line_of
  logic rx_z, rx_bit_zero, ref_rise;
  always_comb
  begin
    // loopback takes the internal nrz bit, so the pins play no part
    if (s_reg.loop)
      rx_z = ~tx_bit(s_reg);
    else if (s_reg.sir)
      rx_z = serial_receive_line;
    else
      rx_z = ~serial_receive_line;
    rx_bit_zero = (s_reg.sir && !s_reg.loop) ? s_reg.rx_zero : s_reg.rx_mid;
    ref_rise = low_power_baud16_reference & ~s_reg.ref_prev;
  end

  always_comb
  begin
    s_next = s_reg;
    s_next.ref_prev = low_power_baud16_reference;
    // baud x16 enable
    s_next.tick = 1'b0;
    if (s_reg.div_cnt == ucs_pkg::BAUD16_DIV - 7'h01)
    begin
      s_next.div_cnt = 7'h00;
      s_next.tick    = 1'b1;
    end
    else
      s_next.div_cnt = s_reg.div_cnt + 7'h01;
    // pulse from first to fourth reference rise, three full periods
    if (s_reg.lp_on && ref_rise)
    begin
      s_next.lp_cnt = s_reg.lp_cnt + 2'h1;
      if (s_reg.lp_cnt == ucs_pkg::LP_LAST)
        s_next.lp_on = 1'b0;
    end
    // transmitter
    case (s_reg.tx_st)
      ucs_pkg::TX_IDLE:
        if (s_reg.tick && s_reg.tx_full && s_reg.master && s_reg.transmit_section_enable)
        begin
          s_next.tx_st    = ucs_pkg::TX_START;
          s_next.tx_shift = s_reg.tx_buf;
          s_next.tx_full  = 1'b0;
          s_next.tx_tick  = 4'h0;
          s_next.tx_bitn  = 3'h0;
          s_next.lp_on    = 1'b1;
          s_next.lp_cnt   = 2'h0;
        end
      default:
        // enables not checked here, character always completes
        if (s_reg.tick)
        begin
          s_next.tx_tick = s_reg.tx_tick + 4'h1;
          if (s_reg.tx_tick == ucs_pkg::LAST_TICK)
          begin
            s_next.lp_on  = 1'b1;
            s_next.lp_cnt = 2'h0;
            case (s_reg.tx_st)
              ucs_pkg::TX_START: s_next.tx_st = ucs_pkg::TX_DATA;
              ucs_pkg::TX_DATA:
              begin
                s_next.tx_shift = {1'b0, s_reg.tx_shift[7:1]};
                s_next.tx_bitn  = s_reg.tx_bitn + 3'h1;
                if (s_reg.tx_bitn == ucs_pkg::LAST_DATA_BIT)
                  s_next.tx_st = ucs_pkg::TX_STOP;
              end
              default:           s_next.tx_st = ucs_pkg::TX_IDLE;
            endcase
          end
        end
    endcase
    // receiver
    case (s_reg.rx_st)
      ucs_pkg::RX_IDLE:
        // reception needs master and receive enable
        if (s_reg.master && s_reg.receive_section_enable && rx_z)
        begin
          s_next.rx_st   = ucs_pkg::RX_START;
          s_next.rx_tick = 4'h0;
          s_next.rx_bitn = 3'h0;
          s_next.rx_zero = 1'b1;
        end
      default:
        if (s_reg.tick)
        begin
          s_next.rx_tick = s_reg.rx_tick + 4'h1;
          s_next.rx_zero = s_reg.rx_zero | rx_z;
          if (s_reg.rx_tick == ucs_pkg::MID_TICK)
            s_next.rx_mid = rx_z;
          if (s_reg.rx_tick == ucs_pkg::LAST_TICK)
          begin
            s_next.rx_zero = 1'b0;
            case (s_reg.rx_st)
              // false start bit is dropped
              ucs_pkg::RX_START:
                s_next.rx_st = rx_bit_zero ? ucs_pkg::RX_DATA : ucs_pkg::RX_IDLE;
              ucs_pkg::RX_DATA:
              begin
                s_next.rx_shift = {~rx_bit_zero, s_reg.rx_shift[7:1]};
                s_next.rx_bitn  = s_reg.rx_bitn + 3'h1;
                if (s_reg.rx_bitn == ucs_pkg::LAST_DATA_BIT)
                  s_next.rx_st = ucs_pkg::RX_STOP;
              end
              default:
              begin
                s_next.rx_st    = ucs_pkg::RX_IDLE;
                s_next.rx_buf   = s_reg.rx_shift;
                s_next.rx_valid = 1'b1;
              end
            endcase
          end
        end
    endcase
    // bus data phase: write lands before the read data is formed
    if (s_reg.ap_valid && s_reg.ap_write)
    begin
      case (s_reg.ap_addr)
        ucs_pkg::DATA_OFS:
          // full holding register refuses the new character
          if (!s_reg.tx_full)
          begin
            s_next.tx_buf  = hwdata[7:0];
            s_next.tx_full = 1'b1;
          end
        ucs_pkg::CTRL_OFS:
        begin
          s_next.master = hwdata[ucs_pkg::MASTER_BIT];
          s_next.sir    = hwdata[ucs_pkg::SIR_EN_BIT];
          s_next.lp     = hwdata[ucs_pkg::SIR_LP_BIT];
          s_next.loop   = hwdata[ucs_pkg::LOOP_BIT];
          s_next.transmit_section_enable    = hwdata[ucs_pkg::TXE_BIT];
          s_next.receive_section_enable    = hwdata[ucs_pkg::RXE_BIT];
        end
        default: ;
      endcase
    end
    // bus address phase
    s_next.ap_valid = hsel && htrans[1] && hready;
    s_next.ap_write = hwrite;
    s_next.ap_addr  = haddr[11:0];
    s_next.hrdata   = 32'h0000_0000;
    if (s_next.ap_valid && !hwrite)
    begin
      case (haddr[11:0])
        ucs_pkg::DATA_OFS:
        begin
          s_next.hrdata[7:0] = s_next.rx_buf;
          // a character landing this cycle stays flagged
          if (!(s_reg.rx_st == ucs_pkg::RX_STOP && s_next.rx_st == ucs_pkg::RX_IDLE))
            s_next.rx_valid = 1'b0;
        end
        ucs_pkg::STATUS_OFS:
        begin
          s_next.hrdata[ucs_pkg::ST_TX_FULL]  = s_next.tx_full;
          s_next.hrdata[ucs_pkg::ST_TX_BUSY]  = s_next.tx_st != ucs_pkg::TX_IDLE;
          s_next.hrdata[ucs_pkg::ST_RX_VALID] = s_next.rx_valid;
          s_next.hrdata[ucs_pkg::ST_RX_BUSY]  = s_next.rx_st != ucs_pkg::RX_IDLE;
        end
        ucs_pkg::CTRL_OFS:
        begin
          s_next.hrdata[ucs_pkg::MASTER_BIT] = s_next.master;
          s_next.hrdata[ucs_pkg::SIR_EN_BIT] = s_next.sir;
          s_next.hrdata[ucs_pkg::SIR_LP_BIT] = s_next.lp;
          s_next.hrdata[ucs_pkg::LOOP_BIT]   = s_next.loop;
          s_next.hrdata[ucs_pkg::TXE_BIT]    = s_next.transmit_section_enable;
          s_next.hrdata[ucs_pkg::RXE_BIT]    = s_next.receive_section_enable;
        end
        default: ;
      endcase
    end
    s_next.hreadyout = 1'b1;
    // pin level from the coding mode
    s_next.tx_line = line_of(s_next);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_reg        <= '0;
      s_reg.transmit_section_enable    <= ucs_pkg::CTRL_RESET[ucs_pkg::TXE_BIT];
      s_reg.receive_section_enable    <= ucs_pkg::CTRL_RESET[ucs_pkg::RXE_BIT];
      s_reg.tx_line <= 1'b1;
      hresp_reg    <= 1'b0;
    end
    else
    begin
      s_reg     <= s_next;
      hresp_reg <= 1'b0;
    end
  end

  assign hrdata               = s_reg.hrdata;
  assign hreadyout            = s_reg.hreadyout;
  assign hresp                = hresp_reg;
  assign serial_transmit_line = s_reg.tx_line;

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_tx_start_gate: assert property (
    $rose(s_reg.tx_st == ucs_pkg::TX_START) |-> $past(s_reg.master && s_reg.transmit_section_enable))
    else $error("transmit started without both enables");
  chk_tx_completes: assert property (
    s_reg.tx_st == ucs_pkg::TX_DATA |=> s_reg.tx_st != ucs_pkg::TX_IDLE)
    else $error("transmit left a character unfinished");
  chk_rx_start_gate: assert property (
    $rose(s_reg.rx_st == ucs_pkg::RX_START) |-> $past(s_reg.master && s_reg.receive_section_enable))
    else $error("receive started without both enables");
  chk_rx_completes: assert property (
    s_reg.rx_st == ucs_pkg::RX_DATA |=> s_reg.rx_st != ucs_pkg::RX_IDLE)
    else $error("receive left a character unfinished");
  chk_sir_width: assert property (
    s_reg.sir && !s_reg.lp && s_reg.tx_st == ucs_pkg::TX_START
    |-> s_reg.tx_line == (s_reg.tx_tick < ucs_pkg::SIR_TICKS))
    else $error("infrared pulse width wrong");
  chk_lp_end: assert property (
    s_reg.lp_on && ref_rise && s_reg.lp_cnt == ucs_pkg::LP_LAST |=> !s_reg.lp_on)
    else $error("low-power pulse not ended after three periods");
  chk_sir_idle_low: assert property (
    s_reg.sir && s_reg.tx_st == ucs_pkg::TX_IDLE |-> !s_reg.tx_line)
    else $error("infrared line not idle low");
  chk_nrz_level: assert property (
    !s_reg.sir |-> s_reg.tx_line == tx_bit(s_reg))
    else $error("nrz line differs from bit");
  chk_loop_path: assert property (
    s_reg.loop |-> rx_z == ~tx_bit(s_reg))
    else $error("loopback path broken");
  chk_reserved_zero: assert property (
    s_reg.ap_valid && !s_reg.ap_write && s_reg.ap_addr == ucs_pkg::CTRL_OFS
    |-> s_reg.hrdata[6:3] == 4'h0)
    else $error("reserved control bits not zero");
  chk_reset_enables: assert property (
    $rose(reset_n) |-> s_reg.transmit_section_enable && s_reg.receive_section_enable && !s_reg.master)
    else $error("control reset value wrong");

  cov_rx_char: cover property ($rose(s_reg.rx_valid));
  cov_sir_tx: cover property (s_reg.sir && s_reg.tx_st == ucs_pkg::TX_STOP);
  cov_lp_tx: cover property (s_reg.sir && s_reg.lp && $fell(s_reg.lp_on));
endmodule : ucs_serial_port

// *** verification/ucs_line_peer.sv ***
// far-side serial peer: drives the receive line, nrz or infrared coded,
// and a free-running low-power reference. assumes the bench's system clock.
`timescale 1ns/1ns
module ucs_line_peer #(
  parameter int BIT_CLKS = 1072,
  parameter int TICK     = 67,
  parameter int REF_HALF = 5
) (
  // system
  input  wire logic clock,
  // far-side lines
  output logic      line,
  output logic      lp_ref
);
  initial
  begin
    line   = 1'b1;
    lp_ref = 1'b0;
    forever
    begin
      repeat (REF_HALF) @(posedge clock);
      lp_ref <= ~lp_ref;
    end
  end

  task idle(input logic v);
    @(posedge clock);
    line <= v;
  endtask : idle

  // infrared zero bit is a 3-tick high pulse; nrz just holds the level
  task send(input logic [7:0] ch, input logic sir);
    logic [9:0] f;
    int         i;
    f = {1'b1, ch, 1'b0};
    @(posedge clock);
    for (i = 0; i < 10; i++)
    begin
      line <= sir ? ~f[i] : f[i];
      repeat (3 * TICK) @(posedge clock);
      line <= sir ? 1'b0 : f[i];
      repeat (BIT_CLKS - 3 * TICK) @(posedge clock);
    end
  endtask : send
endmodule : ucs_line_peer

// *** verification/uart_control_enables_sir_test.sv ***
// bench for the serial port control block: ahb-lite register access,
// transmit line observation and a line peer on the receive side.
`timescale 1ns/1ns
module uart_control_enables_sir_test;
  localparam int          TICK = int'(ucs_pkg::BAUD16_DIV);
  localparam int          BITC = 16 * TICK;
  localparam int          REFP = 10;
  localparam logic [31:0] CTRL = {20'h000, ucs_pkg::CTRL_OFS};
  localparam logic [31:0] DATA = {20'h000, ucs_pkg::DATA_OFS};
  logic        clock, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic        tx, rx, lp_ref;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          error_cnt, num_checks, w;
  assign hready = hreadyout;

  ucs_serial_port dut (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serial_transmit_line(tx),
    .serial_receive_line(rx), .low_power_baud16_reference(lp_ref));
  ucs_line_peer #(.BIT_CLKS(BITC), .TICK(TICK), .REF_HALF(REFP / 2)) peer (
    .clock(clock), .line(rx), .lp_ref(lp_ref));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // waits for hready high at a rising edge; read data taken at that same edge
  task wait_ready;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask : wait_ready

  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
  endtask : bus

  task tx_frame(input logic [7:0] ch);
    logic [9:0] f;
    int         i;
    f = {1'b1, ch, 1'b0};
    while (tx !== 1'b0) @(negedge clock);
    repeat (BITC / 2) @(negedge clock);
    for (i = 0; i < 10; i++)
    begin
      check({31'h0, tx}, {31'h0, f[i]});
      repeat (BITC) @(negedge clock);
    end
  endtask : tx_frame

  task pulse(output int pw);
    while (tx !== 1'b1) @(negedge clock);
    pw = 0;
    while (tx === 1'b1)
    begin
      pw++;
      @(negedge clock);
    end
  endtask : pulse

  task end_sim;
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial
  begin
    repeat (90000) @(posedge clock);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    reset_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    error_cnt = 0; num_checks = 0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    bus(1'b0, CTRL, 32'h0);
    check(rd, 32'h0000_0300);
    check({30'h0, hreadyout, hresp}, 32'h0000_0002);
    // read-modify-write keeps the reserved bits as read
    bus(1'b1, CTRL, rd | 32'h0000_0086);
    bus(1'b0, CTRL, 32'h0);
    check(rd, 32'h0000_0386);
    bus(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0004, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, CTRL, 32'h0000_0300);
    $display("test registers done");
    // holding register full but master off: line must stay idle
    bus(1'b1, DATA, 32'h0000_00A5);
    w = 0;
    repeat (2 * BITC)
    begin
      @(negedge clock);
      if (tx !== 1'b1)
        w++;
    end
    check(32'(w), 32'h0);
    bus(1'b0, {20'h000, ucs_pkg::STATUS_OFS}, 32'h0);
    check(rd, 32'h0000_0001);
    bus(1'b1, CTRL, 32'h0000_0385);
    fork
      tx_frame(8'hA5);
      begin
        @(negedge clock iff tx === 1'b0);
        repeat (3 * BITC) @(posedge clock);
        bus(1'b1, CTRL, 32'h0000_0285);
      end
    join
    repeat (BITC) @(posedge clock);
    bus(1'b0, DATA, 32'h0);
    check(rd, 32'h0000_00A5);
    $display("test loopback done");
    bus(1'b1, CTRL, 32'h0000_0301);
    fork
      peer.send(8'h3C, 1'b0);
      begin
        repeat (4 * BITC) @(posedge clock);
        bus(1'b1, CTRL, 32'h0000_0300);
      end
    join
    repeat (BITC / 4) @(posedge clock);
    bus(1'b0, DATA, 32'h0);
    check(rd, 32'h0000_003C);
    $display("test receive done");
    peer.idle(1'b0);
    bus(1'b1, CTRL, 32'h0000_0303);
    repeat (4) @(negedge clock);
    check({31'h0, tx}, 32'h0);
    fork
      peer.send(8'h96, 1'b1);
      begin
        bus(1'b1, DATA, 32'h0000_005A);
        pulse(w);
        check(32'(w), 32'(3 * TICK));
      end
    join
    repeat (2 * BITC) @(posedge clock);
    bus(1'b0, DATA, 32'h0);
    check(rd, 32'h0000_0096);
    $display("test infrared done");
    bus(1'b1, CTRL, 32'h0000_0307);
    bus(1'b1, DATA, 32'h0);
    pulse(w);
    check(32'(w), 32'(3 * REFP));
    $display("test low power done");
    end_sim();
  end
endmodule : uart_control_enables_sir_test
